// *** shared/status_cmds_map.svh ***
// bit positions, reset values and response constants for the common command block
// assumes inclusion by bare name from the design file; bench files use literal values
`ifndef STATUS_CMDS_MAP_SVH
`define STATUS_CMDS_MAP_SVH

// ------------------------------------------------------------
// standard event status bits
// ------------------------------------------------------------
`define ESR_OPC_BIT 0
`define ESR_RQC_BIT 1
`define ESR_QYE_BIT 2
`define ESR_DDE_BIT 3
`define ESR_EXE_BIT 4
`define ESR_CME_BIT 5
`define ESR_URQ_BIT 6
`define ESR_PON_BIT 7

// ------------------------------------------------------------
// status byte bits
// ------------------------------------------------------------
`define SB_MAV_BIT 4
`define SB_ESB_BIT 5
`define SB_MSS_BIT 6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ESE_RESET      8'h00
`define SRE_RESET      8'h00
`define ESR_RESET      8'h00
`define COMP_NUM_RESET 4'h1
`define COMPARATOR_SETUP_GROUP_NUM_RESET 4'h1
`define FREQ_50HZ      1'b0

// ------------------------------------------------------------
// response constants
// ------------------------------------------------------------
`define ASCII_ZERO 8'h30
`define ID_LAST    5'h12

`endif

// *** shared/status_cmds_pkg.sv ***
// types shared by the common command block
// assumes the map header supplies all numeric constants
package status_cmds_pkg;

  // decoded command codes from the message parser
  typedef enum logic [3:0] {
    CMD_NONE   = 4'h0,
    CMD_CLS    = 4'h1,
    CMD_ESE    = 4'h2,
    CMD_ESE_Q  = 4'h3,
    CMD_ESR_Q  = 4'h4,
    CMD_IDN_Q  = 4'h5,
    CMD_OPC    = 4'h6,
    CMD_OPC_Q  = 4'h7,
    CMD_RST    = 4'h8,
    CMD_SRE    = 4'h9,
    CMD_SRE_Q  = 4'ha,
    CMD_STB_Q  = 4'hb,
    CMD_HEADER = 4'hc
  } cmd_t;

  // response engine states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_NUM  = 2'b01,
    S_IDN  = 2'b10
  } rsp_state_t;

  // instrument settings touched by reset
  typedef struct packed {
    logic       mode_rv;     // 0 resistance, 1 resistance+voltage
    logic       auto_range;
    logic [1:0] sample_rate; // 0 fast, 1 med, 2 slow
    logic       hold_on;     // 0 free run
    logic       comp_on;
    logic [3:0] comp_num;
    logic       limiter_on;
    logic       comp_auto;
    logic       sense_check;
    logic       freq_60hz;   // 0 means 50 Hz
    logic       header_on;
    logic [3:0] comparator_setup_group_num;    // comparator_setup_group target
  } settings_t;

  // one decoded command
  typedef struct packed {
    logic       valid;
    cmd_t       code;
    logic [7:0] arg;
  } cmd_req_t;

  // response byte stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       hdr;
  } resp_t;

  // whole state of the core
  typedef struct packed {
    rsp_state_t fsm;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] stb;
    logic       rqs;
    logic       opc_pend;
    logic       opcq_pend;
    logic       mute;
    logic       ready;
    settings_t  set;
    logic [7:0] num;
    logic [1:0] dig;
    logic [4:0] rom_idx;
    logic       rom_wait;
    resp_t      out;
  } core_t;

endpackage

// *** logic/id_rom.sv ***
// identification string store with registered read data
// assumes one clock; the address is held until the data is taken
`timescale 1ns/1ns
`default_nettype none

module id_rom #(
  parameter int AW = 5
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic [AW-1:0] addr_i,
  output var  logic [7:0]    data_o
);

  // ------------------------------------------------------------
  // fixed contents: four comma separated fields
  // ------------------------------------------------------------
  // text is arbitrary: "MAKER,MODEL,0,V0.00"
  function automatic logic [7:0] rom_byte(input logic [AW-1:0] a);
    logic [7:0] b;
    b = 8'h00;
    case (a)
      5'h00:   b = 8'h4d;
      5'h01:   b = 8'h41;
      5'h02:   b = 8'h4b;
      5'h03:   b = 8'h45;
      5'h04:   b = 8'h52;
      5'h05:   b = 8'h2c;
      5'h06:   b = 8'h4d;
      5'h07:   b = 8'h4f;
      5'h08:   b = 8'h44;
      5'h09:   b = 8'h45;
      5'h0a:   b = 8'h4c;
      5'h0b:   b = 8'h2c;
      5'h0c:   b = 8'h30;
      5'h0d:   b = 8'h2c;
      5'h0e:   b = 8'h56;
      5'h0f:   b = 8'h30;
      5'h10:   b = 8'h2e;
      5'h11:   b = 8'h30;
      5'h12:   b = 8'h30;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // registered read port
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 8'h00;
    end else begin
      data_o <= rom_byte(addr_i);
    end
  end

endmodule // id_rom

`default_nettype wire

// *** logic/status_common_cmds.sv ***
// common command handling: event status, enables, status byte, opc, id, reset
// assumes a parser upstream delivering decoded commands and a formatter downstream
//
// Functional notes
// [R1] clear-status zeroes event register and summaries
// [R2] clear-status keeps queue, masks, message-available bit
// [R3] event-enable command loads 8-bit mask
// [R4] event-enable mask is zero at power-up
// [R5] mask bits: pon urq cme exe dde qye rqc opc
// [R6] event-enable query returns mask as decimal
// [R7] event-status query returns register then clears
// [R8] identification: maker, model, serial, version fields
// [R9] identification response never carries a header
// [R10] identification query ends responses in message
// [R11] operation-complete sets bit0 when idle
// [R12] operation-complete query answers 1 when idle
// [R13] reset restores measurement and comparator settings
// [R14] reset: sense detector off, 50 Hz mains
// [R15] reset: headers on, setup comparator 1
// [R16] reset leaves status, enables, queues unchanged
// [R17] service enable mask, cleared power-up/interface switch
// [R18] master summary bit6 survives serial poll
// [R19] event summary from enabled event bits
`timescale 1ns/1ns
`default_nettype none
`include "status_cmds_map.svh"

module status_common_cmds (
  input  wire logic                      mclk_i,      // 125 MHz system clock
  input  wire logic                      rst_n_i,     // power-on reset
  input  wire status_cmds_pkg::cmd_req_t cmd_i,       // decoded command
  output var  logic                      cmd_ready_o, // command taken when high
  input  wire logic                      msg_end_i,   // end of program message
  input  wire logic [7:1]                evt_i,       // event pulses, bits 7..1
  input  wire logic                      busy_i,      // earlier actions still running
  input  wire logic                      mav_i,       // output queue holds a message
  input  wire logic                      spoll_i,     // serial poll done
  input  wire logic                      if_switch_i, // active interface switched
  input  wire logic                      resp_ready_i,
  output var  status_cmds_pkg::resp_t    resp_o,      // response byte stream
  output var  logic [7:0]                stb_o,       // status byte
  output var  logic [7:0]                esr_o,       // standard event status
  output var  logic                      srq_o,       // service request
  output var  status_cmds_pkg::settings_t settings_o  // instrument settings
);

  // ------------------------------------------------------------
  // state and id store
  // ------------------------------------------------------------
  status_cmds_pkg::core_t     st_reg;   // all state
  status_cmds_pkg::core_t     st_next;  // its next value
  status_cmds_pkg::settings_t set_dflt; // reset-command defaults
  logic [7:0]                 rom_q;    // id byte at st_reg.rom_idx

  id_rom #(
    .AW (5)
  ) u_id_rom (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .addr_i  (st_reg.rom_idx),
    .data_o  (rom_q)
  );

  // ------------------------------------------------------------
  // reset-command settings
  // ------------------------------------------------------------
  always_comb begin
    // [R13] measurement defaults
    set_dflt             = '0;
    set_dflt.mode_rv     = 1'b0;
    set_dflt.auto_range  = 1'b1;
    set_dflt.sample_rate = 2'h2;
    set_dflt.hold_on     = 1'b0;
    set_dflt.comp_on     = 1'b0;
    set_dflt.comp_num    = `COMP_NUM_RESET;
    set_dflt.limiter_on  = 1'b1;
    set_dflt.comp_auto   = 1'b1;
    // [R14] sense check and mains
    set_dflt.sense_check = 1'b0;
    set_dflt.freq_60hz   = `FREQ_50HZ;
    // [R15] header and setup target
    set_dflt.header_on   = 1'b1;
    set_dflt.comparator_setup_group_num    = `COMPARATOR_SETUP_GROUP_NUM_RESET;
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic       free;    // output slot may load this cycle
    logic [7:0] ev;      // events landing this cycle
    logic       esr_clr; // event register cleared this cycle
    logic       q_start; // numeric query starts
    logic [7:0] q_val;   // its value
    logic [7:0] sum;     // summary bits without mss
    logic       mss;     // master summary
    logic [7:0] dval;    // current decimal digit
    free    = 1'b0;
    ev      = 8'h00;
    esr_clr = 1'b0;
    q_start = 1'b0;
    q_val   = 8'h00;
    sum     = 8'h00;
    mss     = 1'b0;
    dval    = 8'h00;
    st_next = st_reg;

    // output slot handshake
    if (st_reg.out.valid && resp_ready_i) begin
      st_next.out.valid = 1'b0;
    end
    free = !st_reg.out.valid || resp_ready_i;
    // [R5] event bit layout, opc at bit0
    ev[7:1] = evt_i;

    // [R10] new message re-enables responses
    if (msg_end_i) begin
      st_next.mute = 1'b0;
    end

    // command decode, only while idle
    if (cmd_i.valid && st_reg.ready) begin
      case (cmd_i.code)
        status_cmds_pkg::CMD_CLS: begin
          // [R1] clear events; summary follows
          // [R2] masks and mav untouched
          esr_clr = 1'b1;
          st_next.opc_pend = 1'b0;
        end
        status_cmds_pkg::CMD_ESE: begin
          // [R3] load enable mask
          st_next.ese = cmd_i.arg;
        end
        status_cmds_pkg::CMD_ESE_Q: begin
          // [R6] mask as decimal
          q_start = 1'b1;
          q_val   = st_reg.ese;
        end
        status_cmds_pkg::CMD_ESR_Q: begin
          // [R7] read then clear
          q_start = 1'b1;
          q_val   = st_reg.esr;
          esr_clr = 1'b1;
        end
        status_cmds_pkg::CMD_IDN_Q: begin
          // [R8] stream id fields
          if (!st_reg.mute) begin
            st_next.fsm      = status_cmds_pkg::S_IDN;
            st_next.rom_idx  = 5'h00;
            st_next.rom_wait = 1'b1;
          end
          // [R10] mute rest of message
          st_next.mute = !msg_end_i;
        end
        status_cmds_pkg::CMD_OPC: begin
          st_next.opc_pend = 1'b1;
        end
        status_cmds_pkg::CMD_OPC_Q: begin
          st_next.opcq_pend = 1'b1;
        end
        status_cmds_pkg::CMD_RST: begin
          // [R16] only settings change
          st_next.set = set_dflt;
        end
        status_cmds_pkg::CMD_SRE: begin
          // [R17] load service mask
          st_next.sre = cmd_i.arg;
        end
        status_cmds_pkg::CMD_SRE_Q: begin
          q_start = 1'b1;
          q_val   = st_reg.sre;
        end
        status_cmds_pkg::CMD_STB_Q: begin
          q_start = 1'b1;
          q_val   = st_reg.stb;
        end
        status_cmds_pkg::CMD_HEADER: begin
          st_next.set.header_on = cmd_i.arg[0];
        end
        default: begin
          // unknown codes ignored
        end
      endcase
    end

    // [R11] set opc bit once earlier actions finish
    if (st_reg.opc_pend && !busy_i) begin
      ev[`ESR_OPC_BIT]  = 1'b1;
      st_next.opc_pend  = 1'b0;
    end

    // [R12] queue a 1 instead of setting the bit
    if (st_reg.opcq_pend && !busy_i && st_reg.fsm == status_cmds_pkg::S_IDLE) begin
      st_next.opcq_pend = 1'b0;
      q_start = 1'b1;
      q_val   = 8'h01;
    end

    // numeric response start
    if (q_start && !st_next.mute) begin
      st_next.fsm     = status_cmds_pkg::S_NUM;
      st_next.num     = q_val;
      if (q_val >= 8'd100) begin
        st_next.dig = 2'd2;
      end else if (q_val >= 8'd10) begin
        st_next.dig = 2'd1;
      end else begin
        st_next.dig = 2'd0;
      end
    end

    // event register: a set wins over a clear
    st_next.esr = (esr_clr ? `ESR_RESET : st_reg.esr) | ev;

    // response engine
    case (st_reg.fsm)
      status_cmds_pkg::S_NUM: begin
        if (free) begin
          case (st_reg.dig)
            2'd2:    dval = 8'(st_reg.num / 8'd100);
            2'd1:    dval = 8'((st_reg.num / 8'd10) % 8'd10);
            default: dval = 8'(st_reg.num % 8'd10);
          endcase
          st_next.out.valid = 1'b1;
          st_next.out.data  = 8'(`ASCII_ZERO + dval);
          // header flag only moves with a new byte, never under a waiting one
          st_next.out.hdr   = st_reg.set.header_on;
          st_next.out.last  = (st_reg.dig == 2'd0);
          if (st_reg.dig == 2'd0) begin
            st_next.fsm = status_cmds_pkg::S_IDLE;
          end else begin
            st_next.dig = 2'(st_reg.dig - 2'd1);
          end
        end
      end
      status_cmds_pkg::S_IDN: begin
        if (st_reg.rom_wait) begin
          st_next.rom_wait = 1'b0;
        end else if (free) begin
          st_next.out.valid = 1'b1;
          st_next.out.data  = rom_q;
          // [R9] no header on id
          st_next.out.hdr   = 1'b0;
          st_next.out.last  = (st_reg.rom_idx == `ID_LAST);
          st_next.rom_wait  = 1'b1;
          if (st_reg.rom_idx == `ID_LAST) begin
            st_next.fsm = status_cmds_pkg::S_IDLE;
          end else begin
            st_next.rom_idx = 5'(st_reg.rom_idx + 5'd1);
          end
        end
      end
      default: begin
        // idle: nothing to stream
      end
    endcase

    // [R17] interface switch clears service mask
    if (if_switch_i) begin
      st_next.sre = `SRE_RESET;
    end

    // [R19] event summary
    sum[`SB_ESB_BIT] = |(st_next.esr & st_next.ese);
    sum[`SB_MAV_BIT] = mav_i;
    // [R18] master summary held while cause stands
    mss = |(sum & st_next.sre & 8'hbf);
    st_next.stb = sum;
    st_next.stb[`SB_MSS_BIT] = mss;

    // service request: rising summary sets, poll clears, set wins
    if (spoll_i) begin
      st_next.rqs = 1'b0;
    end
    if (mss && !st_reg.stb[`SB_MSS_BIT]) begin
      st_next.rqs = 1'b1;
    end

    // ready when the engine will be idle with nothing queued
    st_next.ready = (st_next.fsm == status_cmds_pkg::S_IDLE) && !st_next.opcq_pend;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg       <= '0;
      // [R4] enable mask zero at power-up
      st_reg.ese   <= `ESE_RESET;
      st_reg.sre   <= `SRE_RESET;
      st_reg.esr   <= `ESR_RESET;
      st_reg.ready <= 1'b1;
      st_reg.set.auto_range  <= 1'b1;
      st_reg.set.sample_rate <= 2'h2;
      st_reg.set.comp_num    <= `COMP_NUM_RESET;
      st_reg.set.limiter_on  <= 1'b1;
      st_reg.set.comp_auto   <= 1'b1;
      st_reg.set.header_on   <= 1'b1;
      st_reg.set.comparator_setup_group_num    <= `COMPARATOR_SETUP_GROUP_NUM_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from state
  // ------------------------------------------------------------
  assign cmd_ready_o = st_reg.ready;
  assign resp_o      = st_reg.out;
  assign stb_o       = st_reg.stb;
  assign esr_o       = st_reg.esr;
  assign srq_o       = st_reg.rqs;
  assign settings_o  = st_reg.set;

endmodule // status_common_cmds

`default_nettype wire

// *** bench/status_cmds_sva.sv ***
// checker for the common command block, watching its ports only
// assumes one clock domain and binding onto status_common_cmds
`timescale 1ns/1ns
`default_nettype none

module status_cmds_sva (
  input wire logic                       mclk_i,
  input wire logic                       rst_n_i,
  input wire status_cmds_pkg::cmd_req_t  cmd_i,
  input wire logic                       cmd_ready_o,
  input wire logic [7:1]                 evt_i,
  input wire logic                       mav_i,
  input wire logic                       busy_i,
  input wire logic                       spoll_i,
  input wire logic                       if_switch_i,
  input wire logic                       resp_ready_i,
  input wire status_cmds_pkg::resp_t     resp_o,
  input wire logic [7:0]                 stb_o,
  input wire logic [7:0]                 esr_o,
  input wire logic                       srq_o,
  input wire status_cmds_pkg::settings_t settings_o
);
  // ------------------------------------------------------------
  // shared clocking and command take
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic take;  // command accepted this edge
  assign take = cmd_i.valid && cmd_ready_o;
  sequence take_of(status_cmds_pkg::cmd_t c);
    take && cmd_i.code == c;
  endsequence
  sequence quiet;
    evt_i == 7'h00;
  endsequence

  chk_cls_clears_esr: assert property (take_of(status_cmds_pkg::CMD_CLS) ##0 quiet |=> esr_o == 8'h00)
    else $error("clear-status left event bits");
  chk_mav_bit_copy: assert property ($stable(mav_i) [*3] |-> stb_o[4] == mav_i)
    else $error("status byte bit4 differs from mav");
  chk_evt_bits_set: assert property ((evt_i != 7'h00) |=> (esr_o[7:1] & $past(evt_i)) == $past(evt_i))
    else $error("event pulse not latched");
  chk_esrq_clears: assert property (take_of(status_cmds_pkg::CMD_ESR_Q) ##0 quiet |=> esr_o == 8'h00)
    else $error("event query did not clear");
  chk_resp_holds: assert property (resp_o.valid && !resp_ready_i |=> resp_o.valid && $stable(resp_o.data))
    else $error("response byte dropped");
  chk_idn_no_hdr: assert property (take_of(status_cmds_pkg::CMD_IDN_Q) ##0 resp_ready_i |-> ##3 (resp_o.valid && !resp_o.hdr))
    else $error("id response missing or with header");
  chk_opc_waits: assert property (busy_i [*3] |-> !$rose(esr_o[0]))
    else $error("opc bit set while busy");
  chk_rst_defaults: assert property (take_of(status_cmds_pkg::CMD_RST) |=> settings_o.header_on && settings_o.comparator_setup_group_num == 4'h1 && !settings_o.freq_60hz && !settings_o.sense_check)
    else $error("reset defaults wrong");
  chk_rst_keeps_esr: assert property (take_of(status_cmds_pkg::CMD_RST) ##0 quiet |=> $stable(esr_o))
    else $error("reset touched event register");
  chk_srq_by_poll: assert property ($fell(srq_o) |-> $past(spoll_i))
    else $error("service request fell without poll");
  chk_mss_survives: assert property ((spoll_i && stb_o[6] && !take && !if_switch_i && $stable(mav_i)) ##0 quiet
    |=> stb_o[6])
    else $error("master summary cleared by poll");
  chk_esb_idle: assert property ((esr_o == 8'h00) [*2] |-> !stb_o[5])
    else $error("event summary without events");
endmodule // status_cmds_sva

bind status_common_cmds status_cmds_sva chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
  .cmd_ready_o(cmd_ready_o), .evt_i(evt_i), .mav_i(mav_i), .busy_i(busy_i), .spoll_i(spoll_i),
  .if_switch_i(if_switch_i),
  .resp_ready_i(resp_ready_i), .resp_o(resp_o), .stb_o(stb_o), .esr_o(esr_o), .srq_o(srq_o),
  .settings_o(settings_o));
`default_nettype wire

// *** bench/host_sink.sv ***
// host model taking response bytes, stalling on every second cycle when slow
// assumes decimal ascii numbers and comma separated id fields
`timescale 1ns/1ns
`default_nettype none

module host_sink (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   slow_i,  // stall every other cycle
  input  wire logic                   clr_i,   // start of a new answer
  input  wire status_cmds_pkg::resp_t resp_i,
  output logic                        ready_o
);
  logic [31:0] val;     // decoded number
  logic [31:0] n;       // bytes taken
  logic [31:0] commas;  // field separators seen
  logic        any_hdr; // some byte asked for a header
  logic        done;    // last byte taken
  logic        tog;     // stall phase
  assign ready_o = slow_i ? tog : 1'b1;
  // take bytes only on valid and ready
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog <= 1'b0;
    end else begin
      tog <= !tog;
      if (clr_i) begin
        {val, n, commas, any_hdr, done} <= '0;
      end else if (resp_i.valid && ready_o) begin
        n <= n + 32'h1;
        any_hdr <= any_hdr | resp_i.hdr;
        done <= resp_i.last;
        if (resp_i.data == 8'h2c) commas <= commas + 32'h1;
        else val <= val * 32'ha + {24'h0, resp_i.data - 8'h30};
      end
    end
  end
endmodule // host_sink
`default_nettype wire

// *** bench/testbench.sv ***
// testbench for the common command block, sequences of command calls
// assumes the host model consumes every response byte
`timescale 1ns/1ns
`default_nettype none

module testbench;

  // ------------------------------------------------------------
  // stimulus and observed nets
  // ------------------------------------------------------------
  logic                       mclk    = 1'b0;
  logic                       rst_n   = 1'b0;
  status_cmds_pkg::cmd_req_t  cmd     = '0;
  logic                       msg_end = 1'b0;
  logic [7:1]                 evt     = 7'h00;
  logic                       busy    = 1'b0;
  logic                       mav     = 1'b0;
  logic                       spoll   = 1'b0;
  logic                       if_sw   = 1'b0;
  logic                       slow    = 1'b0;  // host stalls every other cycle
  logic                       clr     = 1'b0;  // host starts a new answer
  logic                       rdy;             // host ready
  logic                       cmd_rdy;
  status_cmds_pkg::resp_t     resp;
  logic [7:0]                 stb;
  logic [7:0]                 esr;
  logic                       srq;
  status_cmds_pkg::settings_t sets;
  int                         n_errors        = 0;
  int                         samples_checked = 0;
  // settings the reset command restores
  localparam status_cmds_pkg::settings_t rst_set = '{mode_rv: 1'b0, auto_range: 1'b1, sample_rate: 2'h2,
    hold_on: 1'b0, comp_on: 1'b0, comp_num: 4'h1, limiter_on: 1'b1, comp_auto: 1'b1, sense_check: 1'b0,
    freq_60hz: 1'b0, header_on: 1'b1, comparator_setup_group_num: 4'h1};

  // free-running 125 MHz clock
  initial begin
    forever #4 mclk = ~mclk;
  end

  status_common_cmds dut (
    .mclk_i       (mclk),
    .rst_n_i      (rst_n),
    .cmd_i        (cmd),
    .cmd_ready_o  (cmd_rdy),
    .msg_end_i    (msg_end),
    .evt_i        (evt),
    .busy_i       (busy),
    .mav_i        (mav),
    .spoll_i      (spoll),
    .if_switch_i  (if_sw),
    .resp_ready_i (rdy),
    .resp_o       (resp),
    .stb_o        (stb),
    .esr_o        (esr),
    .srq_o        (srq),
    .settings_o   (sets)
  );

  host_sink host (
    .mclk_i  (mclk),
    .rst_n_i (rst_n),
    .slow_i  (slow),
    .clr_i   (clr),
    .resp_i  (resp),
    .ready_o (rdy)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one command pulse, raised only while the block is ready
  task automatic send(input status_cmds_pkg::cmd_t c, input logic [7:0] a);
    @(negedge mclk);
    while (!cmd_rdy) @(negedge mclk);
    cmd <= '{valid: 1'b1, code: c, arg: a};
    @(negedge mclk);
    cmd.valid <= 1'b0;
  endtask

  // one-cycle event pulse
  task automatic fire(input logic [7:1] e);
    @(negedge mclk);
    evt <= e;
    @(negedge mclk);
    evt <= 7'h00;
  endtask

  // host forgets the previous answer
  task automatic hclr;
    @(negedge mclk);
    clr <= 1'b1;
    @(negedge mclk);
    clr <= 1'b0;
  endtask

  // wait for the last byte, bounded
  task automatic wait_done;
    int k;
    k = 0;
    while (host.done !== 1'b1 && k < 300) begin
      @(negedge mclk);
      k++;
    end
    check("answer done", host.done, 1);
  endtask

  // numeric answer: value, byte count, header flag
  task automatic wait_resp(input logic [31:0] v, input logic [31:0] nb, input logic h);
    wait_done();
    check("answer value", host.val, v);
    check("answer bytes", host.n, nb);
    check("answer header", host.any_hdr, h);
  endtask

  task automatic ask(input status_cmds_pkg::cmd_t c, input logic [31:0] v, input logic [31:0] nb, input logic h);
    hclr();
    send(c, 8'h00);
    wait_resp(v, nb, h);
  endtask

  // watchdog: the tests need about 200 cycles, allow a hundred times that
  initial begin
    #160000;
    n_errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge mclk);
    rst_n <= 1'b1;
    check("ready", cmd_rdy, 1);
    check("status byte", stb, 8'h00);
    check("settings", sets, rst_set);
    ask(status_cmds_pkg::CMD_ESE_Q, 0, 1, 1'b1);
    // mask load, read back through a stalling host
    send(status_cmds_pkg::CMD_ESE, 8'h24);
    slow <= 1'b1;
    ask(status_cmds_pkg::CMD_ESE_Q, 36, 2, 1'b1);
    slow <= 1'b0;
    // command error event, summary and service request
    fire(7'h10);
    check("event reg", esr, 8'h20);
    check("status byte", stb, 8'h20);
    send(status_cmds_pkg::CMD_SRE, 8'h20);
    check("service request", srq, 1);
    @(negedge mclk);
    spoll <= 1'b1;
    @(negedge mclk);
    spoll <= 1'b0;
    check("service request", srq, 0);
    ask(status_cmds_pkg::CMD_STB_Q, 96, 2, 1'b1);
    ask(status_cmds_pkg::CMD_ESR_Q, 32, 2, 1'b1);
    check("event reg", esr, 8'h00);
    check("status byte", stb, 8'h00);
    // clear-status keeps mav and masks
    mav <= 1'b1;
    fire(7'h02);
    send(status_cmds_pkg::CMD_CLS, 8'h00);
    check("event reg", esr, 8'h00);
    check("status byte", stb, 8'h10);
    ask(status_cmds_pkg::CMD_SRE_Q, 32, 2, 1'b1);
    mav <= 1'b0;
    // opc bit waits for earlier actions
    busy <= 1'b1;
    send(status_cmds_pkg::CMD_OPC, 8'h00);
    repeat (4) @(negedge mclk);
    check("opc early", esr, 8'h00);
    busy <= 1'b0;
    repeat (2) @(negedge mclk);
    check("opc bit", esr, 8'h01);
    ask(status_cmds_pkg::CMD_ESR_Q, 1, 1, 1'b1);
    // opc query answers instead of setting the bit
    busy <= 1'b1;
    hclr();
    send(status_cmds_pkg::CMD_OPC_Q, 8'h00);
    repeat (4) @(negedge mclk);
    check("opc answer early", host.n, 0);
    busy <= 1'b0;
    wait_resp(1, 1, 1'b1);
    check("opc bit", esr, 8'h00);
    // reset command restores settings only
    send(status_cmds_pkg::CMD_HEADER, 8'h00);
    ask(status_cmds_pkg::CMD_ESE_Q, 36, 2, 1'b0);
    fire(7'h40);
    send(status_cmds_pkg::CMD_RST, 8'h00);
    check("settings", sets, rst_set);
    check("event reg", esr, 8'h80);
    ask(status_cmds_pkg::CMD_ESE_Q, 36, 2, 1'b1);
    ask(status_cmds_pkg::CMD_ESR_Q, 128, 3, 1'b1);
    // identification, then muted until message end
    hclr();
    send(status_cmds_pkg::CMD_IDN_Q, 8'h00);
    wait_done();
    check("id bytes", host.n, 19);
    check("id fields", host.commas, 3);
    check("id header", host.any_hdr, 0);
    fire(7'h08);
    hclr();
    send(status_cmds_pkg::CMD_ESR_Q, 8'h00);
    repeat (6) @(negedge mclk);
    check("muted bytes", host.n, 0);
    check("event reg", esr, 8'h00);
    @(negedge mclk);
    msg_end <= 1'b1;
    @(negedge mclk);
    msg_end <= 1'b0;
    ask(status_cmds_pkg::CMD_ESE_Q, 36, 2, 1'b1);
    // interface switch drops the service mask
    @(negedge mclk);
    if_sw <= 1'b1;
    @(negedge mclk);
    if_sw <= 1'b0;
    ask(status_cmds_pkg::CMD_SRE_Q, 0, 1, 1'b1);
    // second reset in mid-run
    @(negedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(negedge mclk);
    rst_n <= 1'b1;
    check("settings", sets, rst_set);
    ask(status_cmds_pkg::CMD_ESE_Q, 0, 1, 1'b1);
    tally_and_finish();
  end

endmodule // testbench
`default_nettype wire
